// ===== pkg/jhmp_regs.vh
// constants of the host message port: commands, status layout, sizes
// Behaviour
// - store qualified messages in two buffers, interrupt
// - message read out in received byte order
// - status shows current receive buffer full
// - receive flush discards current buffer at once
// - read-out or flushed buffer is freed
// - transmit flush empties transmit buffer immediately
// - flush during sending aborts the transmission
// - keep message until sent or dropped
// - status byte returned on every serial transfer
// - retry twice after errors, then drop, report
// - frames with any error are discarded
`ifndef JHMP_REGS_VH
`define JHMP_REGS_VH
`define JHMP_CMD_NOP      8'h00
`define JHMP_CMD_DATA     8'h04
`define JHMP_CMD_LAST     8'h0C
`define JHMP_CMD_READ     8'h02
`define JHMP_CMD_RX_BUFFER_FLUSH 8'h03
`define JHMP_CMD_TX_BUFFER_FLUSH 8'hE0
`define JHMP_CMD_NORETRY  8'h80
`define JHMP_ST_RX_AVAIL  7
`define JHMP_ST_RX_OTHER  6
`define JHMP_ST_TX_EMPTY  5
`define JHMP_ST_TX_BUSY   4
`define JHMP_ST_TX_FAIL   3
`define JHMP_ST_BUS_ACT   2
`define JHMP_TX_TRIES     2'h3
`define JHMP_MSG_DEPTH    12
`define JHMP_RXF_DEPTH    32
`endif

// ===== design/jhmp_port.v
// host message port: serial command slave, transmit buffer, two receive buffers
`include "jhmp_regs.vh"

module jhmp_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = `JHMP_RXF_DEPTH,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) | (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  always @(posedge mclk) begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

module jhmp_port #(
  parameter MSG_DEPTH = `JHMP_MSG_DEPTH,
  parameter POS_W     = 4
) (
  // clock and reset
  input  wire       mclk,
  input  wire       resetn,
  // serial link from host
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_mosi,
  output wire       spi_miso,
  output wire       spi_miso_oe,
  // interrupt to host
  output wire       int_out,
  // transmit stream to bus engine
  output wire [7:0] tx_data,
  output wire       tx_last,
  output wire       tx_valid,
  input  wire       tx_ready,
  output wire       tx_abort,
  input  wire       tx_ok,
  input  wire       tx_err,
  input  wire       tx_arb_lost,
  input  wire       bus_idle,
  input  wire       bus_active,
  // receive stream from bus engine
  input  wire [7:0] rx_data,
  input  wire       rx_last,
  input  wire       rx_err,
  input  wire       rx_valid,
  output wire       rx_ready
);
  localparam TS_IDLE = 2'd0;
  localparam TS_SEND = 2'd1;
  localparam TS_WAIT = 2'd2;
  localparam TS_BACK = 2'd3;

  function [POS_W:0] slot;
    input            b;
    input [POS_W-1:0] p;
    slot = {b, p};
  endfunction

  // synchronisers: sclk, cs_n, mosi
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg       sclk_d_reg;
  reg       cs_d_reg;
  wire      sclk_s = sync2_reg[2];
  wire      cs_act = ~sync2_reg[1];
  wire      mosi_s = sync2_reg[0];
  wire      sclk_rise = sclk_s & ~sclk_d_reg & cs_act;
  wire      sclk_fall = ~sclk_s & sclk_d_reg & cs_act;
  wire      cs_start  = cs_act & ~cs_d_reg;

  reg [2:0] bit_cnt_reg;
  reg       byte_idx_reg;
  reg [6:0] shift_in_reg;
  reg [7:0] cmd_reg;
  reg [7:0] status_reg;
  reg [7:0] rd_byte_reg;
  reg       miso_reg;

  // transmit side
  reg [7:0]       txm [0:MSG_DEPTH-1];
  reg [POS_W:0]   tx_len_reg;
  reg             tx_queued_reg;
  reg [POS_W-1:0] tx_rd_reg;
  reg [1:0]       tx_tries_reg;
  reg             tx_fail_reg;
  reg             no_retry_reg;
  reg [1:0]       tx_state_reg;
  reg             tx_abort_reg;

  // receive side
  reg [7:0]       rxm [0:2*MSG_DEPTH-1];
  reg [POS_W:0]   rx_len_reg [0:1];
  reg [1:0]       rx_full_reg;
  reg             wbuf_reg;
  reg [POS_W:0]   wpos_reg;
  reg             wbad_reg;
  reg             rbuf_reg;
  reg [POS_W-1:0] rpos_reg;

  wire [9:0] f_data;
  wire       f_valid;
  wire       f_ready = ~rx_full_reg[wbuf_reg];

  jhmp_fifo #(.WIDTH(10), .DEPTH(`JHMP_RXF_DEPTH), .AW(5)) u_rx_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   ({rx_err, rx_last, rx_data}),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  wire [7:0] in_byte  = {shift_in_reg, mosi_s};
  wire       byte_end = sclk_rise & (bit_cnt_reg == 3'd7);
  wire       done_b0  = byte_end & ~byte_idx_reg;
  wire       done_b1  = byte_end & byte_idx_reg;
  wire       rx_avail = rx_full_reg[rbuf_reg];
  wire       rx_flush = done_b0 & (in_byte == `JHMP_CMD_RX_BUFFER_FLUSH) & rx_avail;
  wire       rx_take  = done_b1 & (cmd_reg == `JHMP_CMD_READ) & rx_avail;
  wire       tx_flush = done_b0 & (in_byte == `JHMP_CMD_TX_BUFFER_FLUSH);
  wire       tx_load  = done_b1 & ((cmd_reg == `JHMP_CMD_DATA) | (cmd_reg == `JHMP_CMD_LAST))
                        & ~tx_queued_reg & (tx_len_reg < MSG_DEPTH);
  wire       tx_empty = ~tx_queued_reg & (tx_len_reg == {(POS_W+1){1'b0}});
  wire [7:0] status_now;
  assign status_now = {rx_avail, rx_full_reg[~rbuf_reg], tx_empty,
                       tx_state_reg != TS_IDLE, tx_fail_reg, bus_active, 2'b00};

  assign spi_miso    = miso_reg;
  assign spi_miso_oe = cs_act;
  assign int_out     = |rx_full_reg;
  assign tx_valid    = tx_state_reg == TS_SEND;
  assign tx_data     = txm[tx_rd_reg];
  assign tx_last     = ({1'b0, tx_rd_reg} + 1'b1) == tx_len_reg;
  assign tx_abort    = tx_abort_reg;

  // serial slave, mode 3: drive on falling edge, sample on rising edge
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg    <= 3'h7;
      sync2_reg    <= 3'h7;
      sclk_d_reg   <= 1'b1;
      cs_d_reg     <= 1'b0;
      bit_cnt_reg  <= 3'd0;
      byte_idx_reg <= 1'b0;
      shift_in_reg <= 7'h00;
      cmd_reg      <= `JHMP_CMD_NOP;
      status_reg   <= 8'h00;
      rd_byte_reg  <= 8'h00;
      miso_reg     <= 1'b0;
    end else begin
      sync1_reg  <= {spi_sclk, spi_cs_n, spi_mosi};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_act;
      if (!cs_act) begin
        bit_cnt_reg  <= 3'd0;
        byte_idx_reg <= 1'b0;
      end else if (cs_start) begin
        status_reg <= status_now;
      end else begin
        if (sclk_fall)
          miso_reg <= byte_idx_reg ? rd_byte_reg[~bit_cnt_reg] : status_reg[~bit_cnt_reg];
        if (sclk_rise) begin
          shift_in_reg <= in_byte[6:0];
          bit_cnt_reg  <= bit_cnt_reg + 3'd1;
        end
        if (byte_end)
          byte_idx_reg <= ~byte_idx_reg;
        if (done_b0) begin
          cmd_reg     <= in_byte;
          rd_byte_reg <= rx_avail ? rxm[slot(rbuf_reg, rpos_reg)] : 8'h00;
        end
        if (done_b1)
          status_reg <= status_now;
      end
    end
  end

  // transmit buffer and retry sequencing
  always @(posedge mclk) begin
    if (tx_load)
      txm[tx_len_reg[POS_W-1:0]] <= in_byte;
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_len_reg    <= {(POS_W+1){1'b0}};
      tx_queued_reg <= 1'b0;
      tx_rd_reg     <= {POS_W{1'b0}};
      tx_tries_reg  <= 2'd0;
      tx_fail_reg   <= 1'b0;
      no_retry_reg  <= 1'b0;
      tx_state_reg  <= TS_IDLE;
      tx_abort_reg  <= 1'b0;
    end else begin
      tx_abort_reg <= 1'b0;
      if (done_b0 && in_byte == `JHMP_CMD_NORETRY)
        no_retry_reg <= 1'b1;
      if (tx_flush) begin
        tx_len_reg    <= {(POS_W+1){1'b0}};
        tx_queued_reg <= 1'b0;
        tx_state_reg  <= TS_IDLE;
        tx_abort_reg  <= tx_state_reg != TS_IDLE;
      end else begin
        if (tx_load) begin
          tx_len_reg <= tx_len_reg + 1'b1;
          if (cmd_reg == `JHMP_CMD_LAST) begin
            tx_queued_reg <= 1'b1;
            tx_fail_reg   <= 1'b0;
            no_retry_reg  <= 1'b0;
          end
        end
        case (tx_state_reg)
          TS_IDLE: begin
            if (tx_queued_reg) begin
              tx_rd_reg    <= {POS_W{1'b0}};
              tx_tries_reg <= 2'd0;
              tx_state_reg <= TS_SEND;
            end
          end
          TS_SEND: begin
            if (tx_ready) begin
              if (tx_last)
                tx_state_reg <= TS_WAIT;
              else
                tx_rd_reg <= tx_rd_reg + 1'b1;
            end
          end
          TS_WAIT: begin
            if (tx_ok) begin
              tx_len_reg    <= {(POS_W+1){1'b0}};
              tx_queued_reg <= 1'b0;
              tx_state_reg  <= TS_IDLE;
            end else if (tx_err) begin
              tx_tries_reg <= tx_tries_reg + 2'd1;
              if (tx_tries_reg + 2'd1 == `JHMP_TX_TRIES || no_retry_reg) begin
                tx_len_reg    <= {(POS_W+1){1'b0}};
                tx_queued_reg <= 1'b0;
                tx_fail_reg   <= 1'b1;
                tx_state_reg  <= TS_IDLE;
              end else begin
                tx_state_reg <= TS_BACK;
              end
            end else if (tx_arb_lost) begin
              tx_state_reg <= TS_BACK;
            end
          end
          TS_BACK: begin
            if (bus_idle) begin
              tx_rd_reg    <= {POS_W{1'b0}};
              tx_state_reg <= TS_SEND;
            end
          end
          default: tx_state_reg <= TS_IDLE;
        endcase
      end
    end
  end

  // receive buffers: filled alternately, read back in the same order
  always @(posedge mclk) begin
    if (f_valid && f_ready && wpos_reg < MSG_DEPTH)
      rxm[slot(wbuf_reg, wpos_reg[POS_W-1:0])] <= f_data[7:0];
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_len_reg[0] <= {(POS_W+1){1'b0}};
      rx_len_reg[1] <= {(POS_W+1){1'b0}};
      rx_full_reg   <= 2'b00;
      wbuf_reg      <= 1'b0;
      wpos_reg      <= {(POS_W+1){1'b0}};
      wbad_reg      <= 1'b0;
      rbuf_reg      <= 1'b0;
      rpos_reg      <= {POS_W{1'b0}};
    end else begin
      // fill stalls while the target buffer is still held, so the fifo backs up
      if (f_valid && f_ready) begin
        if (f_data[8]) begin
          wpos_reg <= {(POS_W+1){1'b0}};
          wbad_reg <= 1'b0;
          if (!(wbad_reg || f_data[9] || wpos_reg >= MSG_DEPTH)) begin
            rx_full_reg[wbuf_reg] <= 1'b1;
            rx_len_reg[wbuf_reg]  <= wpos_reg + 1'b1;
            wbuf_reg              <= ~wbuf_reg;
          end
        end else begin
          wbad_reg <= wbad_reg | f_data[9] | (wpos_reg >= MSG_DEPTH);
          if (wpos_reg < MSG_DEPTH)
            wpos_reg <= wpos_reg + 1'b1;
        end
      end
      if (rx_flush || (rx_take && ({1'b0, rpos_reg} + 1'b1) == rx_len_reg[rbuf_reg])) begin
        rx_full_reg[rbuf_reg] <= 1'b0;
        rbuf_reg              <= ~rbuf_reg;
        rpos_reg              <= {POS_W{1'b0}};
      end else if (rx_take) begin
        rpos_reg <= rpos_reg + 1'b1;
      end
    end
  end
endmodule

// ===== dv/jhmp_port_monitor.sv
// assertion checker for the host message port
module jhmp_port_monitor (
  // clock, reset, link
  input wire       mclk,
  input wire       resetn,
  input wire       spi_cs_n,
  input wire       spi_miso_oe,
  // outputs and tx_ready
  input wire       int_out,
  input wire [7:0] tx_data,
  input wire       tx_last,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       tx_abort
);
  timeunit 1ns;
  timeprecision 100ps;
  // cycles of select high, saturating
  logic [3:0] idle_reg;
  always @(posedge mclk or negedge resetn)
    if (!resetn) idle_reg <= 4'h0;
    else if (!spi_cs_n) idle_reg <= 4'h0;
    else if (idle_reg != 4'hF) idle_reg <= idle_reg + 4'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_oe_idle: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso enabled while unselected");
  chk_oe_selected: assert property ((!spi_cs_n) [*4] |-> spi_miso_oe)
    else $error("miso not enabled while selected");
  chk_abort_pulse: assert property (tx_abort |=> !tx_abort)
    else $error("abort longer than one cycle");
  chk_abort_stops: assert property (tx_abort |-> ##[0:2] !tx_valid)
    else $error("sending goes on after abort");
  chk_byte_hold: assert property (tx_valid && !tx_ready |=>
      !tx_valid || ($stable(tx_data) && $stable(tx_last)))
    else $error("byte changed while stalled");
  chk_wait_last: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("valid after final byte");
  chk_int_held: assert property (int_out && idle_reg > 4'h7 |=> int_out)
    else $error("interrupt dropped without host access");
  chk_int_fall: assert property ($fell(int_out) |-> idle_reg < 4'h8)
    else $error("interrupt fell outside a transfer");
endmodule
bind jhmp_port jhmp_port_monitor i_jhmp_port_monitor (.mclk, .resetn, .spi_cs_n,
  .spi_miso_oe, .int_out, .tx_data, .tx_last, .tx_valid, .tx_ready, .tx_abort);

// ===== dv/jhmp_host_model.sv
// host serial master model: clock idles high, 160 ns period, one pair per select
module jhmp_host_model (
  // serial link
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input  wire  spi_miso,
  input  wire  spi_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {spi_sclk, spi_cs_n, spi_mosi} = 3'b111;
  task automatic pair(input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {c, d};
    spi_cs_n = 1'b0;
    #80;
    for (int k = 15; k >= 0; k--) begin
      spi_sclk = 1'b0;
      spi_mosi = sh[k];
      #80;
      spi_sclk = 1'b1;
      sh[k] = spi_miso_oe ? spi_miso : 1'b1;
      #80;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line must not look held
    {st, rd} = sh;
    #240;
  endtask
endmodule

// ===== dv/jhmp_port_tb.sv
// self-checking bench for the host message port
`include "jhmp_regs.vh"
module jhmp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk = 1'b0, resetn = 1'b0, tx_ready = 1'b0, tx_ok = 1'b0;
  logic       tx_err = 1'b0, tx_arb_lost = 1'b0, bus_idle = 1'b1, bus_active = 1'b0;
  logic       rx_last = 1'b0, rx_err = 1'b0, rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00, st, rd;
  wire        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, rx_ready;
  wire        int_out, tx_last, tx_valid, tx_abort;
  wire  [7:0] tx_data;
  int         n_errors = 0, tests_run = 0, cycles = 0, n_abort = 0;
  jhmp_port i_jhmp_port (.mclk, .resetn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .int_out, .tx_data, .tx_last, .tx_valid, .tx_ready, .tx_abort, .tx_ok,
    .tx_err, .tx_arb_lost, .bus_idle, .bus_active, .rx_data, .rx_last, .rx_err, .rx_valid,
    .rx_ready);
  jhmp_host_model i_jhmp_host_model (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe);
  always #4 mclk = ~mclk;
  // run needs about 10k cycles
  always @(posedge mclk) begin
    cycles++;
    if (tx_abort === 1'b1) n_abort++;
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
  end
  task final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task eq(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task await(input bit irq);
    for (int w = 0; w < 400 && (irq ? int_out : tx_valid) !== 1'b1; w++) cyc(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task px(input logic [7:0] c);
    i_jhmp_host_model.pair(c, 8'h00, st, rd);
  endtask
  task load(input logic [7:0] b0, input int n);
    px(`JHMP_CMD_NOP);
    for (int p = 0; p < 8 && st[5] !== 1'b1; p++) px(`JHMP_CMD_NOP);
    eq(st & 8'h20, 8'h20);
    for (int k = 0; k < n; k++)
      i_jhmp_host_model.pair(k == n - 1 ? `JHMP_CMD_LAST : `JHMP_CMD_DATA,
                             b0 + 8'(k), st, rd);
  endtask
  // stalls first so the byte must hold
  task sink(input logic [7:0] b0, input int n);
    int k;
    k = 0;
    cyc(1);
    await(1'b0);
    cyc(3);
    tx_ready = 1'b1;
    while (k < n) begin
      if (tx_valid === 1'b1) begin
        eq(tx_data, b0 + 8'(k));
        eq(8'(tx_last), 8'(k == n - 1));
        k++;
      end
      cyc(1);
    end
    tx_ready = 1'b0;
  endtask
  task rxf(input int n, input int bad);
    cyc(1);
    rx_valid = 1'b1;
    for (int k = 0; k < n; k++) begin
      rx_data = 8'hA0 | 8'(k);
      {rx_last, rx_err} = {k == n - 1, k == bad};
      while (rx_ready !== 1'b1) cyc(1);
      cyc(1);
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  task t_send();
    bus_active = 1'b1;
    load(8'h03, 3);
    px(`JHMP_CMD_NOP);
    eq(st & 8'h34, 8'h14);
    sink(8'h03, 3);
    bus_active = 1'b0;
    pulse(tx_ok);
    px(`JHMP_CMD_NOP);
    eq(st & 8'h2C, 8'h20);
  endtask
  task t_flush();
    int a0;
    load(8'h20, 2);
    await(1'b0);
    a0 = n_abort;
    px(`JHMP_CMD_TX_BUFFER_FLUSH);
    cyc(1);
    eq(8'(n_abort - a0), 8'h01);
    eq(8'(tx_valid), 8'h00);
    load(8'h40, 1);
    sink(8'h40, 1);
    px(`JHMP_CMD_NORETRY);
    cyc(1);
    pulse(tx_err);
    cyc(8);
    eq(8'(tx_valid), 8'h00);
  endtask
  task t_retry();
    load(8'h55, 1);
    sink(8'h55, 1);
    pulse(tx_arb_lost);
    for (int a = 0; a < 3; a++) begin
      sink(8'h55, 1);
      bus_idle = 1'b0;
      pulse(tx_err);
      cyc(8);
      eq(8'(tx_valid), 8'h00);
      bus_idle = 1'b1;
    end
    px(`JHMP_CMD_NOP);
    eq(st & 8'h28, 8'h28);
  endtask
  task t_rx();
    rxf(4, -1);
    await(1'b1);
    eq(8'(int_out), 8'h01);
    for (int k = 0; k < 5; k++) begin
      px(k < 4 ? `JHMP_CMD_READ : `JHMP_CMD_NOP);
      eq(st & 8'h80, k < 4 ? 8'h80 : 8'h00);
      if (k < 4) eq(rd, 8'hA0 | 8'(k));
    end
    eq(8'(int_out), 8'h00);
    rxf(3, 1);
    await(1'b1);
    eq(8'(int_out), 8'h00);
    rxf(4, -1);
    await(1'b1);
    // second frame lands in the other buffer while this one is held
    rxf(4, -1);
    cyc(20);
    px(`JHMP_CMD_READ);
    eq(st & 8'hC0, 8'hC0);
    eq(rd, 8'hA0);
    px(`JHMP_CMD_RX_BUFFER_FLUSH);
    px(`JHMP_CMD_NOP);
    eq(st & 8'hC0, 8'h80);
    px(`JHMP_CMD_RX_BUFFER_FLUSH);
    px(`JHMP_CMD_NOP);
    eq(st & 8'h80, 8'h00);
    eq(8'(int_out), 8'h00);
  endtask
  initial begin
    cyc(8);
    resetn = 1'b1;
    cyc(3);
    t_send();
    t_flush();
    t_retry();
    t_rx();
    final_report();
  end
endmodule
